//--- verilog/ubt_defines.svh
`ifndef TRX_DEFINES_SVH
`define TRX_DEFINES_SVH

// Bits per direction of the data path
`define TRX_WIDTH        17
// Value that the data store takes under reset
`define TRX_DATA_RST     1'b0
// Clock history and synchronised clock pins start high, so that a clock
// that is already high at release is not taken for a rising edge
`define TRX_CLK_PREV_RST 1'b1
// Synchronised active-low output enables start released
`define TRX_OE_N_RST     1'b1
// Value of the other synchroniser stages and output flops under reset
`define TRX_SYNC_RST     1'b0
// Output enables are off under reset
`define TRX_OE_RST       1'b0

`endif

//--- verilog/ubt_pkg.sv
`include "ubt_defines.svh"

package trx_pkg;

  // Path controls of one direction
  typedef struct packed {
    logic clock_enable_n;
    logic latch_enable;
    logic clock;
  } dir_ctrl_t;

  // Every pin that the device samples
  typedef struct packed {
    dir_ctrl_t                ab;
    dir_ctrl_t                ba;
    logic                     ab_output_enable_n;
    logic                     ba_output_enable_n;
    logic                     edge_rate_select;
    logic                     backplane_clock_in;
    logic [`TRX_WIDTH-1:0]    a_data;
    logic [`TRX_WIDTH-1:0]    b_data;
  } pin_in_t;

endpackage

//--- verilog/ubt_dir_path.sv
`timescale 1ns/1ps
`include "ubt_defines.svh"

module trx_dir_path #(
  parameter int WIDTH = `TRX_WIDTH
) (
  input  wire logic               i_clk_sys, // System clock
  input  wire logic               i_rst_n,   // Async reset, active low
  input  wire trx_pkg::dir_ctrl_t i_ctrl,    // Synchronised path controls
  input  wire logic [WIDTH-1:0]   i_data,    // Synchronised source data
  output logic      [WIDTH-1:0]   o_q        // Stored or passed data
);

  logic [WIDTH-1:0] q_r;
  logic [WIDTH-1:0] q_nxt;
  logic             clk_prev_r;
  logic             clk_prev_nxt;
  logic             clk_rise;

  assign clk_rise = i_ctrl.clock & ~clk_prev_r;
  assign o_q      = q_r;

  always_comb
  begin
    clk_prev_nxt = i_ctrl.clock;
    if (i_ctrl.latch_enable)
      q_nxt = i_data;
    else if (!i_ctrl.clock_enable_n && clk_rise)
      q_nxt = i_data;
    else
      q_nxt = q_r;
  end

  always_ff @(posedge i_clk_sys or negedge i_rst_n)
  begin
    if (!i_rst_n)
    begin
      q_r        <= {WIDTH{`TRX_DATA_RST}};
      clk_prev_r <= `TRX_CLK_PREV_RST;
    end
    else
    begin
      q_r        <= q_nxt;
      clk_prev_r <= clk_prev_nxt;
    end
  end

  steady_hold_a: assert property (
    @(posedge i_clk_sys) disable iff (!i_rst_n)
    !i_ctrl.latch_enable && !i_ctrl.clock_enable_n
      && (i_ctrl.clock == clk_prev_r) |=> $stable(q_r))
    else $error("stored data moved with a steady clock");

  latch_close_a: assert property (
    @(posedge i_clk_sys) disable iff (!i_rst_n)
    !i_ctrl.latch_enable && $past(i_ctrl.latch_enable)
      && i_ctrl.clock && clk_prev_r |-> q_r == $past(i_data))
    else $error("latch did not keep the value seen before closing");

  clock_capture_a: assert property (
    @(posedge i_clk_sys) disable iff (!i_rst_n)
    !i_ctrl.latch_enable && !i_ctrl.clock_enable_n && i_ctrl.clock
      && !clk_prev_r |=> q_r == $past(i_data))
    else $error("rising clock did not capture the data");

  inhibit_hold_a: assert property (
    @(posedge i_clk_sys) disable iff (!i_rst_n)
    !i_ctrl.latch_enable && i_ctrl.clock_enable_n |=> $stable(q_r))
    else $error("data moved while the clock was inhibited");

  transparent_pass_a: assert property (
    @(posedge i_clk_sys) disable iff (!i_rst_n)
    i_ctrl.latch_enable |=> q_r == $past(i_data))
    else $error("transparent mode did not pass the data");

endmodule // trx_dir_path

//--- verilog/ubt_transceiver.sv
`timescale 1ns/1ps
`include "ubt_defines.svh"

module trx_transceiver (
  input  wire logic                  i_clk_sys,              // System clock
  input  wire logic                  i_rst_n,                // Reset, low
  input  wire logic                  i_ab_clock_enable_n,    // A-to-B clk en
  input  wire logic                  i_ab_output_enable_n,   // B drive, low
  input  wire logic                  i_ab_latch_enable,      // A-to-B latch
  input  wire logic                  i_ab_clock,             // A-to-B clock
  input  wire logic                  i_ba_clock_enable_n,    // B-to-A clk en
  input  wire logic                  i_ba_output_enable_n,   // A drive, low
  input  wire logic                  i_ba_latch_enable,      // B-to-A latch
  input  wire logic                  i_ba_clock,             // B-to-A clock
  input  wire logic                  i_edge_rate_select,     // High is fast
  input  wire logic [`TRX_WIDTH-1:0] i_a_data,               // A pin level
  input  wire logic [`TRX_WIDTH-1:0] i_b_data,               // B pin level
  input  wire logic                  i_backplane_clock_in,   // Clock pin lvl
  output logic      [`TRX_WIDTH-1:0] o_a_data,               // A drive value
  output logic                       o_a_oe,                 // A drive on
  output logic      [`TRX_WIDTH-1:0] o_b_data,               // B drive value
  output logic                       o_b_oe,                 // B drive on
  output logic                       o_backplane_clock_out,  // Clock value
  output logic                       o_backplane_clock_out_oe, // Clock on
  output logic                       o_card_clock_return,    // Return value
  output logic                       o_card_clock_return_oe, // Return on
  output logic                       o_b_fast_edge           // Fast B edges
);

  trx_pkg::pin_in_t pins;
  trx_pkg::pin_in_t sync1_r;
  trx_pkg::pin_in_t sync2_r;
  trx_pkg::pin_in_t sync1_nxt;
  trx_pkg::pin_in_t sync2_nxt;

  logic a_oe_r;
  logic a_oe_nxt;
  logic b_oe_r;
  logic b_oe_nxt;
  logic bp_clk_r;
  logic bp_clk_nxt;
  logic bp_clk_oe_r;
  logic bp_clk_oe_nxt;
  logic ret_clk_r;
  logic ret_clk_nxt;
  logic ret_clk_oe_r;
  logic ret_clk_oe_nxt;
  logic fast_edge_r;
  logic fast_edge_nxt;

  logic [`TRX_WIDTH-1:0] ab_q;
  logic [`TRX_WIDTH-1:0] ba_q;

  // Synchroniser reset image: output enables released and clocks high, so that
  // nothing drives and no clock edge is seen in the cycles after release
  localparam trx_pkg::dir_ctrl_t CTRL_RST = '{
    clock_enable_n : `TRX_SYNC_RST,
    latch_enable   : `TRX_SYNC_RST,
    clock          : `TRX_CLK_PREV_RST
  };
  localparam trx_pkg::pin_in_t PINS_RST = '{
    ab                 : CTRL_RST,
    ba                 : CTRL_RST,
    ab_output_enable_n : `TRX_OE_N_RST,
    ba_output_enable_n : `TRX_OE_N_RST,
    edge_rate_select   : `TRX_SYNC_RST,
    backplane_clock_in : `TRX_CLK_PREV_RST,
    a_data             : {`TRX_WIDTH{`TRX_SYNC_RST}},
    b_data             : {`TRX_WIDTH{`TRX_SYNC_RST}}
  };

  always_comb
  begin
    pins.ab.clock_enable_n  = i_ab_clock_enable_n;
    pins.ab.latch_enable    = i_ab_latch_enable;
    pins.ab.clock           = i_ab_clock;
    pins.ba.clock_enable_n  = i_ba_clock_enable_n;
    pins.ba.latch_enable    = i_ba_latch_enable;
    pins.ba.clock           = i_ba_clock;
    pins.ab_output_enable_n = i_ab_output_enable_n;
    pins.ba_output_enable_n = i_ba_output_enable_n;
    pins.edge_rate_select   = i_edge_rate_select;
    pins.backplane_clock_in = i_backplane_clock_in;
    pins.a_data             = i_a_data;
    pins.b_data             = i_b_data;
  end

  // Two-stage synchroniser on every pin
  always_comb
  begin
    sync1_nxt = pins;
    sync2_nxt = sync1_r;
  end

  always_ff @(posedge i_clk_sys or negedge i_rst_n)
  begin
    if (!i_rst_n)
    begin
      sync1_r <= PINS_RST;
      sync2_r <= PINS_RST;
    end
    else
    begin
      sync1_r <= sync1_nxt;
      sync2_r <= sync2_nxt;
    end
  end

  trx_dir_path #(
    .WIDTH (`TRX_WIDTH)
  ) u_ab_path (
    .i_clk_sys (i_clk_sys),
    .i_rst_n   (i_rst_n),
    .i_ctrl    (sync2_r.ab),
    .i_data    (sync2_r.a_data),
    .o_q       (ab_q)
  );

  // Mirror path, B data towards A
  trx_dir_path #(
    .WIDTH (`TRX_WIDTH)
  ) u_ba_path (
    .i_clk_sys (i_clk_sys),
    .i_rst_n   (i_rst_n),
    .i_ctrl    (sync2_r.ba),
    .i_data    (sync2_r.b_data),
    .o_q       (ba_q)
  );

  assign o_b_data = ab_q;
  assign o_a_data = ba_q;

  // Drive enables, buffered clock path and edge-rate choice
  always_comb
  begin
    b_oe_nxt       = ~sync2_r.ab_output_enable_n;
    a_oe_nxt       = ~sync2_r.ba_output_enable_n;
    bp_clk_nxt     = sync2_r.ab.clock;
    bp_clk_oe_nxt  = ~sync2_r.ab_output_enable_n;
    ret_clk_nxt    = sync2_r.backplane_clock_in;
    ret_clk_oe_nxt = ~sync2_r.ba_output_enable_n;
    fast_edge_nxt  = sync2_r.edge_rate_select;
  end

  always_ff @(posedge i_clk_sys or negedge i_rst_n)
  begin
    if (!i_rst_n)
    begin
      a_oe_r       <= `TRX_OE_RST;
      b_oe_r       <= `TRX_OE_RST;
      bp_clk_r     <= `TRX_SYNC_RST;
      bp_clk_oe_r  <= `TRX_OE_RST;
      ret_clk_r    <= `TRX_SYNC_RST;
      ret_clk_oe_r <= `TRX_OE_RST;
      fast_edge_r  <= `TRX_SYNC_RST;
    end
    else
    begin
      a_oe_r       <= a_oe_nxt;
      b_oe_r       <= b_oe_nxt;
      bp_clk_r     <= bp_clk_nxt;
      bp_clk_oe_r  <= bp_clk_oe_nxt;
      ret_clk_r    <= ret_clk_nxt;
      ret_clk_oe_r <= ret_clk_oe_nxt;
      fast_edge_r  <= fast_edge_nxt;
    end
  end

  assign o_a_oe                   = a_oe_r;
  assign o_b_oe                   = b_oe_r;
  assign o_backplane_clock_out    = bp_clk_r;
  assign o_backplane_clock_out_oe = bp_clk_oe_r;
  assign o_card_clock_return      = ret_clk_r;
  assign o_card_clock_return_oe   = ret_clk_oe_r;
  assign o_b_fast_edge            = fast_edge_r;

  clock_forward_a: assert property (
    @(posedge i_clk_sys) disable iff (!i_rst_n)
    !sync2_r.ab_output_enable_n |=> o_backplane_clock_out_oe
      && o_backplane_clock_out == $past(sync2_r.ab.clock))
    else $error("enabled side did not forward its clock");

  clock_return_a: assert property (
    @(posedge i_clk_sys) disable iff (!i_rst_n)
    !sync2_r.ba_output_enable_n |=> o_card_clock_return_oe
      && o_card_clock_return == $past(sync2_r.backplane_clock_in))
    else $error("backplane clock not returned to the card");

  feedback_drive_a: assert property (
    @(posedge i_clk_sys) disable iff (!i_rst_n)
    !sync2_r.ab_output_enable_n && !sync2_r.ba_output_enable_n
      |=> o_backplane_clock_out_oe && o_card_clock_return_oe)
    else $error("feedback path not driving both clocks");

  edge_rate_a: assert property (
    @(posedge i_clk_sys) disable iff (!i_rst_n)
    ##1 o_b_fast_edge == $past(sync2_r.edge_rate_select))
    else $error("edge-rate output does not follow its select");

  b_side_float_a: assert property (
    @(posedge i_clk_sys) disable iff (!i_rst_n)
    sync2_r.ab_output_enable_n |=> !o_b_oe && !o_backplane_clock_out_oe)
    else $error("B side driven while disabled");

  a_side_float_a: assert property (
    @(posedge i_clk_sys) disable iff (!i_rst_n)
    sync2_r.ba_output_enable_n |=> !o_a_oe && !o_card_clock_return_oe)
    else $error("A side driven while disabled");

  clock_isolate_a: assert property (
    @(posedge i_clk_sys) disable iff (!i_rst_n)
    sync2_r.ab_output_enable_n && sync2_r.ba_output_enable_n
      |=> !o_backplane_clock_out_oe && !o_card_clock_return_oe)
    else $error("clock outputs not isolated");

  b_side_drive_a: assert property (
    @(posedge i_clk_sys) disable iff (!i_rst_n)
    !sync2_r.ab_output_enable_n |=> o_b_oe)
    else $error("B side not driven while enabled");

  a_side_drive_a: assert property (
    @(posedge i_clk_sys) disable iff (!i_rst_n)
    !sync2_r.ba_output_enable_n |=> o_a_oe)
    else $error("A side not driven while enabled");

endmodule // trx_transceiver

//--- bench/backplane_model.sv
`timescale 1ns/1ps
`include "ubt_defines.svh"

module backplane_model (
  input  wire logic                  i_b_oe,      // Device drives B
  input  wire logic [`TRX_WIDTH-1:0] i_b_drive,   // Device B value
  input  wire logic                  i_far_drive, // Other card drives B
  input  wire logic [`TRX_WIDTH-1:0] i_far_data,  // Other card B value
  input  wire logic                  i_clk_oe,    // Device drives clock
  input  wire logic                  i_clk_drive, // Device clock value
  output logic      [`TRX_WIDTH-1:0] o_b_wire,    // Resolved B lines
  output logic                       o_clk_wire   // Resolved clock line
);
  // Terminated lines float high when released; a driven low wins
  always_comb
  begin
    o_b_wire = '1;
    if (i_far_drive)
      o_b_wire = i_far_data;
    if (i_b_oe)
      o_b_wire = o_b_wire & i_b_drive;
    o_clk_wire = i_clk_oe ? i_clk_drive : 1'b1;
  end
endmodule // backplane_model

//--- bench/universal_bus_transceiver_path_test.sv
`timescale 1ns/1ps
`include "ubt_defines.svh"
`define CHK(got, exp) \
  begin compares++; if ((got) !== (exp)) begin n_fail++; \
  $display("BAD t=%0t got=%h exp=%h", $time, (got), (exp)); end end

module universal_bus_transceiver_path_test;
  logic                  i_clk_sys;
  logic                  i_rst_n;
  trx_pkg::pin_in_t      pins;
  logic                  far_drive;
  logic [`TRX_WIDTH-1:0] b_wire;
  logic                  clk_wire;
  logic [`TRX_WIDTH-1:0] o_a_data;
  logic                  o_a_oe;
  logic [`TRX_WIDTH-1:0] o_b_data;
  logic                  o_b_oe;
  logic                  o_backplane_clock_out;
  logic                  o_backplane_clock_out_oe;
  logic                  o_card_clock_return;
  logic                  o_card_clock_return_oe;
  logic                  o_b_fast_edge;
  int                    n_fail;
  int                    compares;

  trx_transceiver u_dut (
    .i_clk_sys                (i_clk_sys),
    .i_rst_n                  (i_rst_n),
    .i_ab_clock_enable_n      (pins.ab.clock_enable_n),
    .i_ab_output_enable_n     (pins.ab_output_enable_n),
    .i_ab_latch_enable        (pins.ab.latch_enable),
    .i_ab_clock               (pins.ab.clock),
    .i_ba_clock_enable_n      (pins.ba.clock_enable_n),
    .i_ba_output_enable_n     (pins.ba_output_enable_n),
    .i_ba_latch_enable        (pins.ba.latch_enable),
    .i_ba_clock               (pins.ba.clock),
    .i_edge_rate_select       (pins.edge_rate_select),
    .i_a_data                 (pins.a_data),
    .i_b_data                 (b_wire),
    .i_backplane_clock_in     (clk_wire),
    .o_a_data                 (o_a_data),
    .o_a_oe                   (o_a_oe),
    .o_b_data                 (o_b_data),
    .o_b_oe                   (o_b_oe),
    .o_backplane_clock_out    (o_backplane_clock_out),
    .o_backplane_clock_out_oe (o_backplane_clock_out_oe),
    .o_card_clock_return      (o_card_clock_return),
    .o_card_clock_return_oe   (o_card_clock_return_oe),
    .o_b_fast_edge            (o_b_fast_edge)
  );

  backplane_model u_far (
    .i_b_oe      (o_b_oe),
    .i_b_drive   (o_b_data),
    .i_far_drive (far_drive),
    .i_far_data  (pins.b_data),
    .i_clk_oe    (o_backplane_clock_out_oe),
    .i_clk_drive (o_backplane_clock_out),
    .o_b_wire    (b_wire),
    .o_clk_wire  (clk_wire)
  );

  initial
  begin
    i_clk_sys = 1'b0;
    forever #5 i_clk_sys = ~i_clk_sys;
  end

  // Two sync stages plus output flop, one more for sampling phase
  task automatic settle();
    repeat (4) @(posedge i_clk_sys);
    #1;
  endtask

  task automatic pulse_ab();
    pins.ab.clock = 1'b0;
    settle();
    pins.ab.clock = 1'b1;
    settle();
  endtask

  task automatic pulse_ba();
    pins.ba.clock = 1'b0;
    settle();
    pins.ba.clock = 1'b1;
    settle();
  endtask

  task automatic tally_and_finish();
    if (n_fail == 0 && compares > 0)
      $display("verification passed");
    else
      $display("verification failed");
    $finish;
  endtask

  initial
  begin
    #50000;
    n_fail++;
    tally_and_finish();
  end

  initial
  begin
    n_fail = 0;
    compares = 0;
    pins = '0;
    pins.ab_output_enable_n = 1'b1;
    pins.ba_output_enable_n = 1'b1;
    far_drive = 1'b0;
    i_rst_n = 1'b0;
    repeat (4) @(posedge i_clk_sys);
    #1;
    `CHK(o_b_oe, 1'b0)
    `CHK(o_a_oe, 1'b0)
    i_rst_n = 1'b1;
    // Nothing may drive while the idle enables pass the synchroniser
    repeat (3)
    begin
      @(posedge i_clk_sys);
      #1;
      `CHK(o_b_oe, 1'b0)
      `CHK(o_a_oe, 1'b0)
      `CHK(o_backplane_clock_out_oe, 1'b0)
    end
    // A to B: transparent, latch close with clock high, clocked, inhibit
    pins.ab_output_enable_n = 1'b0;
    pins.ab.latch_enable = 1'b1;
    pins.a_data = 17'h1a5a5;
    settle();
    `CHK(o_b_oe, 1'b1)
    `CHK(o_b_data, 17'h1a5a5)
    pins.a_data = 17'h05a5a;
    pins.ab.clock = 1'b1;
    settle();
    `CHK(o_b_data, 17'h05a5a)
    pins.ab.latch_enable = 1'b0;
    settle();
    pins.a_data = 17'h1ffff;
    settle();
    `CHK(o_b_data, 17'h05a5a)
    pins.ab.clock = 1'b0;
    settle();
    `CHK(o_b_data, 17'h05a5a)
    pins.ab.clock = 1'b1;
    settle();
    `CHK(o_b_data, 17'h1ffff)
    pins.a_data = 17'h00001;
    pulse_ab();
    `CHK(o_b_data, 17'h00001)
    pins.ab.clock_enable_n = 1'b1;
    pins.a_data = 17'h0f0f0;
    pulse_ab();
    `CHK(o_b_data, 17'h00001)
    pins.ab_output_enable_n = 1'b1;
    settle();
    `CHK(o_b_oe, 1'b0)
    // B to A from the far card
    far_drive = 1'b1;
    pins.b_data = 17'h12345;
    pins.ba_output_enable_n = 1'b0;
    pins.ba.latch_enable = 1'b1;
    settle();
    `CHK(o_a_oe, 1'b1)
    `CHK(o_a_data, 17'h12345)
    pins.ba.latch_enable = 1'b0;
    pins.b_data = 17'h0abcd;
    pulse_ba();
    `CHK(o_a_data, 17'h0abcd)
    pins.ba.clock_enable_n = 1'b1;
    pins.b_data = 17'h00001;
    pulse_ba();
    `CHK(o_a_data, 17'h0abcd)
    far_drive = 1'b0;
    // Clock path; both enables low only here
    for (int i = 0; i < 4; i++)
      for (int c = 0; c < 2; c++)
      begin
        pins.ab_output_enable_n = i[0];
        pins.ba_output_enable_n = i[1];
        pins.ab.clock = c[0];
        // The returned clock crosses the device twice: out, then back in
        settle();
        settle();
        `CHK(o_backplane_clock_out_oe, !i[0])
        `CHK(o_card_clock_return_oe, !i[1])
        if (!i[0])
          `CHK(o_backplane_clock_out, c[0])
        if (!i[1])
          `CHK(o_card_clock_return, i[0] | c[0])
      end
    for (int e = 0; e < 2; e++)
    begin
      pins.edge_rate_select = e[0];
      settle();
      `CHK(o_b_fast_edge, e[0])
    end
    tally_and_finish();
  end
endmodule // universal_bus_transceiver_path_test
